// *** design/lbf_regs.svh ***
// Constants for the learning bridge filter: sizes, field positions and timing
`ifndef LBF_REGS_SVH
`define LBF_REGS_SVH

// ------------------------------------------------------------
// Storage sizes
// ------------------------------------------------------------
`define LBF_BUF_DEPTH      2048
`define LBF_BUF_AW         11
`define LBF_LEN_W          12
`define LBF_TAB_N          16
`define LBF_TAB_IW         4
`define LBF_FIFO_DEPTH     16
`define LBF_IDLE_W         12

// ------------------------------------------------------------
// Frame layout
// ------------------------------------------------------------
`define LBF_MAC_W          48
`define LBF_DST_END        12'd6
`define LBF_SRC_END        12'd12
`define LBF_MIN_LEN        12'd14
`define LBF_GROUP_BIT      40

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define LBF_CLK_HZ         50000000
`define LBF_TICK_MS        1000
`define LBF_TICK_CYCLES    (`LBF_CLK_HZ / 1000 * `LBF_TICK_MS)
`define LBF_AGE_FULL_MIN   2
`define LBF_AGE_WG_MIN     32
`define LBF_AGE_FULL_TICKS (`LBF_AGE_FULL_MIN * 60000 / `LBF_TICK_MS)
`define LBF_AGE_WG_TICKS   (`LBF_AGE_WG_MIN * 60000 / `LBF_TICK_MS)

`endif

// *** design/lbf_pkg.sv ***
// Types shared by the learning bridge filter, its sink model and its testbench
`include "lbf_regs.svh"

package lbf_pkg;

  // ------------------------------------------------------------
  // Ports, beats and table entries
  // ------------------------------------------------------------
  typedef enum logic {
    LBF_WIRED,
    LBF_WIRELESS
  } lbf_port_t;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
    logic       err;
  } lbf_rx_t;

  typedef struct packed {
    lbf_port_t  port;
    logic [7:0] data;
    logic       last;
  } lbf_tx_t;

  typedef struct packed {
    logic                   valid;
    lbf_port_t              port;
    logic [`LBF_MAC_W-1:0]  mac;
    logic [`LBF_IDLE_W-1:0] idle;
  } lbf_entry_t;

  typedef lbf_entry_t [`LBF_TAB_N-1:0] lbf_tab_t;

  typedef struct packed {
    logic                   hit;
    logic [`LBF_TAB_IW-1:0] idx;
  } lbf_find_t;

  typedef enum logic [1:0] {
    LBF_RECV,
    LBF_DECIDE,
    LBF_SEND
  } lbf_state_t;

endpackage

// *** design/lbf_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides
module lbf_fifo #(
  parameter int W     = 10,
  parameter int DEPTH = 16
) (
  input  wire logic         ref_clk,
  input  wire logic         resetn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0]   cnt_r;
  wire           push = in_valid && in_ready;
  wire           pop  = out_valid && out_ready;

  // Honest flags from the occupancy count
  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem[rd_r];

  // Storage writes
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wr_r <= wr_r + 1'b1;
      if (pop) rd_r <= rd_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  a_fifo_no_over: assert property (@(posedge ref_clk) disable iff (!resetn)
    cnt_r <= (AW+1)'(DEPTH)) else $error("fifo count above depth");

endmodule

// *** design/lbf_bridge.sv ***
// Store-and-forward learning bridge between a wired and a wireless port
`include "lbf_regs.svh"

module lbf_bridge
  import lbf_pkg::*;
#(
  parameter int TICK_CYCLES = `LBF_TICK_CYCLES
) (
  input  wire logic      ref_clk,
  input  wire logic      resetn,
  input  wire logic      mode_full,
  input  wire lbf_port_t rx_port,
  input  wire logic      rx_valid,
  input  wire lbf_rx_t   rx_beat,
  output logic           rx_ready,
  output logic           tx_valid,
  output lbf_tx_t        tx_beat,
  input  wire logic      tx_ready,
  output logic           fwd_pulse,
  output logic           drop_pulse
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic lbf_find_t lbf_find(lbf_tab_t tab, logic [`LBF_MAC_W-1:0] mac);
    lbf_find_t f;
    f = '0;
    for (int i = 0; i < `LBF_TAB_N; i++) begin
      if (tab[i].valid && tab[i].mac == mac) begin
        f.hit = 1'b1;
        f.idx = `LBF_TAB_IW'(i);
      end
    end
    return f;
  endfunction

  function automatic lbf_find_t lbf_free(lbf_tab_t tab);
    lbf_find_t f;
    f = '0;
    for (int i = `LBF_TAB_N - 1; i >= 0; i--) begin
      if (!tab[i].valid) begin
        f.hit = 1'b1;
        f.idx = `LBF_TAB_IW'(i);
      end
    end
    return f;
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [7:0]             buf_mem [`LBF_BUF_DEPTH];
  lbf_state_t             state_r;
  lbf_state_t             state_nxt;
  logic [`LBF_LEN_W-1:0]  len_r;
  logic [`LBF_LEN_W-1:0]  rd_r;
  logic [`LBF_MAC_W-1:0]  dst_r;
  logic [`LBF_MAC_W-1:0]  src_r;
  lbf_port_t              port_r;
  lbf_tab_t               tab_r;
  logic [`LBF_TAB_IW-1:0] victim_r;
  logic [31:0]            tick_cnt_r;
  logic                   tick_r;
  logic                   rx_ready_r;
  logic                   tx_valid_r;
  lbf_tx_t                tx_beat_r;
  logic                   fwd_r;
  logic                   drop_r;

  // ------------------------------------------------------------
  // Receive decode
  // ------------------------------------------------------------
  wire rx_take  = rx_valid && rx_ready_r;
  wire rx_end   = rx_take && rx_beat.last;
  wire rx_good  = !rx_beat.err && (len_r + 1'b1 >= `LBF_MIN_LEN)
                  && (len_r < `LBF_LEN_W'(`LBF_BUF_DEPTH));
  wire in_frame = (len_r != '0);
  lbf_port_t arr_port;
  assign arr_port = in_frame ? port_r : rx_port;

  // ------------------------------------------------------------
  // Lookup and decision
  // ------------------------------------------------------------
  lbf_find_t  dst_f;
  lbf_find_t  src_f;
  lbf_find_t  free_f;
  lbf_entry_t dst_ent;
  assign dst_f   = lbf_find(tab_r, dst_r);
  assign src_f   = lbf_find(tab_r, src_r);
  assign free_f  = lbf_free(tab_r);
  assign dst_ent = tab_r[dst_f.idx];

  wire dst_mc   = dst_r[`LBF_GROUP_BIT];
  wire src_mc   = src_r[`LBF_GROUP_BIT];
  wire dst_local = dst_f.hit && (dst_ent.port == port_r);
  wire dst_wl   = dst_f.hit && (dst_ent.port == LBF_WIRELESS);
  // Workgroup is the fallback whenever the full-mode pin is low
  wire fwd_wg   = !dst_local && (dst_mc || dst_wl);
  wire fwd_full = !dst_local;
  wire fwd_w    = mode_full ? fwd_full : fwd_wg;

  // Learning is blind to payload; port, mode and the source group bit gate it
  wire learn_ok = mode_full || (port_r == LBF_WIRELESS);
  wire decide   = (state_r == LBF_DECIDE);
  wire learn_en = decide && learn_ok && !src_mc;
  wire [`LBF_TAB_IW-1:0] learn_idx = src_f.hit ? src_f.idx :
                                     free_f.hit ? free_f.idx : victim_r;
  wire refresh  = decide && dst_f.hit;

  wire [`LBF_IDLE_W-1:0] age_limit = mode_full ? `LBF_IDLE_W'(`LBF_AGE_FULL_TICKS)
                                               : `LBF_IDLE_W'(`LBF_AGE_WG_TICKS);

  // ------------------------------------------------------------
  // Forwarding path into the output FIFO
  // ------------------------------------------------------------
  lbf_tx_t fifo_in;
  lbf_tx_t fifo_out;
  logic    fifo_in_ready;
  logic    fifo_out_valid;
  wire     sending   = (state_r == LBF_SEND);
  wire     send_last = (rd_r == len_r - 1'b1);
  wire     push      = sending && fifo_in_ready;
  wire     tx_load   = !tx_valid_r || tx_ready;

  assign fifo_in.port = (port_r == LBF_WIRED) ? LBF_WIRELESS : LBF_WIRED;
  assign fifo_in.data = buf_mem[rd_r[`LBF_BUF_AW-1:0]];
  assign fifo_in.last = send_last;

  lbf_fifo #(
    .W     ($bits(lbf_tx_t)),
    .DEPTH (`LBF_FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .in_valid  (sending),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (fifo_out_valid),
    .out_ready (tx_load),
    .out_data  (fifo_out)
  );

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      LBF_RECV: begin
        if (rx_end && rx_good) state_nxt = LBF_DECIDE;
      end
      LBF_DECIDE: begin
        state_nxt = fwd_w ? LBF_SEND : LBF_RECV;
      end
      LBF_SEND: begin
        if (push && send_last) state_nxt = LBF_RECV;
      end
    endcase
  end

  // Frame buffer writes; bytes beyond the buffer are discarded
  always_ff @(posedge ref_clk) begin
    if (rx_take && len_r < `LBF_LEN_W'(`LBF_BUF_DEPTH)) begin
      buf_mem[len_r[`LBF_BUF_AW-1:0]] <= rx_beat.data;
    end
  end

  // Receive counters and header capture
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      len_r  <= '0;
      dst_r  <= '0;
      src_r  <= '0;
      port_r <= LBF_WIRED;
    end else if (rx_take) begin
      port_r <= arr_port;
      // A rejected frame frees the buffer at once so the next one starts clean
      len_r  <= (rx_beat.last && !rx_good) ? '0 : len_r + 1'b1;
      if (len_r < `LBF_DST_END) dst_r <= {dst_r[39:0], rx_beat.data};
      else if (len_r < `LBF_SRC_END) src_r <= {src_r[39:0], rx_beat.data};
    end else if (state_r == LBF_RECV) begin
      len_r <= len_r;
    end else if (state_nxt == LBF_RECV) begin
      len_r <= '0;
    end
  end

  // Control state, strobes and send pointer
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_r    <= LBF_RECV;
      rd_r       <= '0;
      rx_ready_r <= 1'b0;
      fwd_r      <= 1'b0;
      drop_r     <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      rd_r       <= push ? rd_r + 1'b1 : (sending ? rd_r : '0);
      rx_ready_r <= (state_nxt == LBF_RECV) && !(rx_end && rx_good);
      fwd_r      <= decide && fwd_w;
      drop_r     <= (decide && !fwd_w) || (rx_end && !rx_good);
    end
  end

  // Coarse aging tick; one per second keeps counters small
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
    end else begin
      tick_r     <= (tick_cnt_r == 32'(TICK_CYCLES - 1));
      tick_cnt_r <= (tick_cnt_r == 32'(TICK_CYCLES - 1)) ? '0 : tick_cnt_r + 1'b1;
    end
  end

  // Address table: aging, then refresh and learning take priority
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tab_r    <= '0;
      victim_r <= '0;
    end else begin
      for (int i = 0; i < `LBF_TAB_N; i++) begin
        if (tick_r && tab_r[i].valid) begin
          if (tab_r[i].idle + 1'b1 >= age_limit) tab_r[i].valid <= 1'b0;
          else tab_r[i].idle <= tab_r[i].idle + 1'b1;
        end else if (tab_r[i].valid && tab_r[i].idle >= age_limit) begin
          // A switch to the shorter interval expires old entries without waiting a tick
          tab_r[i].valid <= 1'b0;
        end
        if (refresh && dst_f.idx == `LBF_TAB_IW'(i)) begin
          tab_r[i].idle <= '0;
          tab_r[i].valid <= 1'b1;
        end
        if (learn_en && learn_idx == `LBF_TAB_IW'(i)) begin
          tab_r[i] <= '{valid: 1'b1, port: port_r, mac: src_r, idle: '0};
        end
      end
      // Full table: evict round-robin rather than refuse to learn
      if (learn_en && !src_f.hit && !free_f.hit) victim_r <= victim_r + 1'b1;
    end
  end

  // Output register stage keeps tx pins straight from flops
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tx_valid_r <= 1'b0;
      tx_beat_r  <= '0;
    end else if (tx_load) begin
      tx_valid_r <= fifo_out_valid;
      tx_beat_r  <= fifo_out;
    end
  end

  assign rx_ready   = rx_ready_r;
  assign tx_valid   = tx_valid_r;
  assign tx_beat    = tx_beat_r;
  assign fwd_pulse  = fwd_r;
  assign drop_pulse = drop_r;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence s_decide_fwd;
    decide && fwd_w;
  endsequence

  sequence s_send_start;
    state_r == LBF_SEND && $past(state_r) == LBF_DECIDE;
  endsequence

  a_store_fwd: assert property (@(posedge ref_clk) disable iff (!resetn)
    $rose(sending) |-> $past(decide)) else $error("send began without a checked frame");

  a_fwd_goes_send: assert property (@(posedge ref_clk) disable iff (!resetn)
    s_decide_fwd |=> s_send_start) else $error("forward decision did not start sending");

  a_local_drop: assert property (@(posedge ref_clk) disable iff (!resetn)
    decide && dst_local |=> state_r == LBF_RECV && drop_r) else $error("local frame not dropped");

  a_learn_insert: assert property (@(posedge ref_clk) disable iff (!resetn)
    learn_en |=> tab_r[$past(learn_idx)].valid && tab_r[$past(learn_idx)].mac == $past(src_r))
    else $error("source address not learned");

  a_refresh_idle: assert property (@(posedge ref_clk) disable iff (!resetn)
    refresh |=> tab_r[$past(dst_f.idx)].idle == '0) else $error("idle time not restarted");

  a_age_expire: assert property (@(posedge ref_clk) disable iff (!resetn)
    tick_r && tab_r[0].valid && tab_r[0].idle + 1'b1 >= age_limit && !learn_en && !refresh
    |=> !tab_r[0].valid) else $error("stale entry not removed");

  a_age_bound: assert property (@(posedge ref_clk) disable iff (!resetn)
    tab_r[0].valid && !$changed(mode_full) |-> tab_r[0].idle < age_limit)
    else $error("idle counter passed the aging interval");

  a_full_learn: assert property (@(posedge ref_clk) disable iff (!resetn)
    decide && mode_full && !src_mc |-> learn_en) else $error("full mode missed learning");

  a_full_unknown: assert property (@(posedge ref_clk) disable iff (!resetn)
    decide && mode_full && !dst_f.hit |=> sending) else $error("unknown destination not forwarded");

  a_wg_nolearn: assert property (@(posedge ref_clk) disable iff (!resetn)
    decide && !mode_full && port_r == LBF_WIRED |-> !learn_en) else $error("workgroup learned wired side");

  a_wg_filter: assert property (@(posedge ref_clk) disable iff (!resetn)
    decide && !mode_full && !dst_mc && !dst_wl |=> !sending) else $error("workgroup forwarded a disallowed frame");

  a_tick_period: assert property (@(posedge ref_clk) disable iff (!resetn)
    tick_r |=> !tick_r) else $error("tick longer than one cycle");

  a_bad_drop: assert property (@(posedge ref_clk) disable iff (!resetn)
    rx_end && !rx_good |=> drop_r && len_r == '0 && state_r == LBF_RECV)
    else $error("bad frame not dropped cleanly");

  a_rx_hold_off: assert property (@(posedge ref_clk) disable iff (!resetn)
    rx_end && rx_good |=> !rx_ready_r && state_r == LBF_DECIDE) else $error("receive not paused for decision");

  a_drop_rx_back: assert property (@(posedge ref_clk) disable iff (!resetn)
    decide && !fwd_w |=> rx_ready_r && !sending) else $error("dropped frame left receive stalled");

  a_tx_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
    tx_valid_r && !tx_ready |=> tx_valid_r && $stable(tx_beat_r)) else $error("output beat changed before taken");

endmodule

// *** verification/lbf_sink_model.sv ***
// Far-side model that accepts bridge output beats and can stall
module lbf_sink_model
  import lbf_pkg::*;
(
  input  wire logic    ref_clk,
  input  wire logic    resetn,
  input  wire logic    tx_valid,
  input  wire lbf_tx_t tx_beat,
  output logic         tx_ready,
  input  wire logic    stall,
  input  wire logic    slow
);
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // Capture and pacing
  // ------------------------------------------------------------
  lbf_tx_t got[$];
  logic    phase_r;

  // Ready moves on the falling edge so the bridge sees a steady level
  always @(negedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      phase_r  <= 1'b0;
      tx_ready <= 1'b0;
    end else begin
      phase_r  <= ~phase_r;
      tx_ready <= !stall && (!slow || phase_r);
    end
  end

  // Beats are taken only on an edge with both valid and ready
  always @(posedge ref_clk) begin
    if (resetn && tx_valid === 1'b1 && tx_ready) got.push_back(tx_beat);
  end
endmodule

// *** verification/testbench.sv ***
// Self-checking testbench for the learning bridge filter
`define TB_CHK(what, exp, got) begin num_checks++; if ((got) !== (exp)) begin fails++; \
  $display("[FAIL] %s expected %0h seen %0h", what, exp, got); end end

module testbench
  import lbf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------
  localparam int          TICK  = 10;
  localparam int          LIMIT = 40000;
  localparam logic [47:0] BCAST = 48'hffff_ffff_ffff;
  localparam logic [47:0] MCAST = 48'h0100_5e00_0001;
  logic       ref_clk = 1'b0;
  logic       resetn = 1'b0;
  logic       mode_full = 1'b0;
  lbf_port_t  rx_port = LBF_WIRED;
  logic       rx_valid = 1'b0;
  lbf_rx_t    rx_beat = '0;
  logic       rx_ready;
  logic       tx_valid;
  lbf_tx_t    tx_beat;
  logic       tx_ready;
  logic       fwd_pulse;
  logic       drop_pulse;
  logic       stall = 1'b0;
  logic       slow = 1'b0;
  int         fails = 0;
  int         num_checks = 0;
  int         cycles = 0;
  logic [7:0] frm[$];

  lbf_bridge #(.TICK_CYCLES(TICK)) lbf_bridge_inst (
    .ref_clk(ref_clk), .resetn(resetn), .mode_full(mode_full), .rx_port(rx_port),
    .rx_valid(rx_valid), .rx_beat(rx_beat), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_beat(tx_beat), .tx_ready(tx_ready), .fwd_pulse(fwd_pulse), .drop_pulse(drop_pulse)
  );

  lbf_sink_model lbf_sink_model_inst (
    .ref_clk(ref_clk), .resetn(resetn), .tx_valid(tx_valid), .tx_beat(tx_beat),
    .tx_ready(tx_ready), .stall(stall), .slow(slow)
  );

  // 50 MHz clock and a cycle ceiling against hangs
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fails++;
      close_out();
    end
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  function automatic logic [47:0] mac(input logic [7:0] b);
    return {40'h02_0000_0000, b};
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wait_ticks(input int t);
    repeat (t * TICK) @(negedge ref_clk);
  endtask

  // Offers one frame beat by beat; holds each beat until rx_ready takes it
  task automatic send(input lbf_port_t p, input logic err, output int early);
    int n;
    early = 0;
    rx_port = p;
    for (int i = 0; i < frm.size(); i++) begin
      rx_valid = 1'b1;
      rx_beat = '{data: frm[i], last: (i == frm.size() - 1), err: err && (i == frm.size() - 1)};
      n = 0;
      while (rx_ready !== 1'b1 && n < 5000) begin
        @(negedge ref_clk);
        n++;
      end
      @(negedge ref_clk);
      if (tx_valid !== 1'b0) early++;
    end
    rx_valid = 1'b0;
  endtask

  // Sends a frame, judges forward or drop, then checks every output beat
  task automatic frame(input string nm, input lbf_port_t p, input logic [47:0] dst, input logic [47:0] src,
                       input int len, input logic err, input logic fwd, input int hold);
    int        early;
    int        n;
    logic      f;
    logic      d;
    lbf_port_t op;
    lbf_tx_t   e;
    op = (p == LBF_WIRED) ? LBF_WIRELESS : LBF_WIRED;
    frm = {};
    for (int i = 0; i < len; i++) begin
      frm.push_back(i < 6 ? dst[47 - 8 * i -: 8] : i < 12 ? src[95 - 8 * i -: 8] : 8'(i * 7 + 3));
    end
    lbf_sink_model_inst.got = {};
    send(p, err, early);
    f = 1'b0;
    d = 1'b0;
    for (n = 0; n < 10; n++) begin
      f = fwd_pulse;
      d = drop_pulse;
      if (f === 1'b1 || d === 1'b1) break;
      @(negedge ref_clk);
    end
    `TB_CHK({nm, " early tx"}, 0, early)
    `TB_CHK({nm, " forward"}, fwd, f)
    `TB_CHK({nm, " drop"}, !fwd, d)
    if (hold > 0) begin
      repeat (hold) @(negedge ref_clk);
      `TB_CHK({nm, " rx held off"}, 1'b0, rx_ready)
      `TB_CHK({nm, " tx waiting"}, 1'b1, tx_valid)
      stall = 1'b0;
    end
    n = 0;
    // A dropped frame gets a quiet spell so a stray forward still shows up
    while ((fwd ? lbf_sink_model_inst.got.size() < len : n < 40) && n < 3000) begin
      @(negedge ref_clk);
      n++;
    end
    `TB_CHK({nm, " tx count"}, fwd ? len : 0, lbf_sink_model_inst.got.size())
    for (int i = 0; i < len && i < lbf_sink_model_inst.got.size(); i++) begin
      e = '{port: op, data: frm[i], last: (i == len - 1)};
      `TB_CHK({nm, " tx beat"}, e, lbf_sink_model_inst.got[i])
    end
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_workgroup();
    frame("wg unknown", LBF_WIRED, mac(8'ha1), mac(8'h10), 20, 1'b0, 1'b0, 0);
    frame("wg bcast", LBF_WIRED, BCAST, mac(8'h10), 16, 1'b0, 1'b1, 0);
    frame("wg learn", LBF_WIRELESS, MCAST, mac(8'ha2), 14, 1'b0, 1'b1, 0);
    frame("wg known", LBF_WIRED, mac(8'ha2), mac(8'h10), 30, 1'b0, 1'b1, 0);
    frame("wg wired src", LBF_WIRED, BCAST, mac(8'ha3), 18, 1'b0, 1'b1, 0);
    mode_full = 1'b1;
    frame("wg no learn", LBF_WIRED, mac(8'ha3), mac(8'h10), 18, 1'b0, 1'b1, 0);
    $display("test workgroup done");
  endtask

  task automatic t_full();
    mode_full = 1'b1;
    frame("fb unknown", LBF_WIRED, mac(8'hb1), mac(8'hb2), 24, 1'b0, 1'b1, 0);
    frame("fb local", LBF_WIRED, mac(8'hb2), mac(8'h10), 20, 1'b0, 1'b0, 0);
    frame("fb cross", LBF_WIRELESS, mac(8'hb2), mac(8'h20), 21, 1'b0, 1'b1, 0);
    frame("fb wl local", LBF_WIRELESS, mac(8'ha2), mac(8'h20), 20, 1'b0, 1'b0, 0);
    $display("test full done");
  endtask

  task automatic t_bad();
    frame("bad err", LBF_WIRED, BCAST, mac(8'hc1), 20, 1'b1, 1'b0, 0);
    frame("bad short", LBF_WIRED, BCAST, mac(8'hc2), 13, 1'b0, 1'b0, 0);
    frame("bad no learn", LBF_WIRED, mac(8'hc1), mac(8'h10), 20, 1'b0, 1'b1, 0);
    $display("test bad frames done");
  endtask

  task automatic t_stall();
    stall = 1'b1;
    slow = 1'b1;
    frame("stall", LBF_WIRELESS, BCAST, mac(8'h20), 60, 1'b0, 1'b1, 40);
    slow = 1'b0;
    $display("test stall done");
  endtask

  task automatic t_age_full();
    mode_full = 1'b1;
    frame("age learn", LBF_WIRELESS, BCAST, mac(8'hd1), 16, 1'b0, 1'b1, 0);
    wait_ticks(100);
    frame("age hit 1", LBF_WIRELESS, mac(8'hd1), mac(8'h20), 16, 1'b0, 1'b0, 0);
    wait_ticks(100);
    frame("age hit 2", LBF_WIRELESS, mac(8'hd1), mac(8'h20), 16, 1'b0, 1'b0, 0);
    wait_ticks(125);
    frame("age gone", LBF_WIRELESS, mac(8'hd1), mac(8'h20), 16, 1'b0, 1'b1, 0);
    $display("test full aging done");
  endtask

  task automatic t_age_wg();
    mode_full = 1'b0;
    frame("wg age learn", LBF_WIRELESS, BCAST, mac(8'he1), 16, 1'b0, 1'b1, 0);
    wait_ticks(200);
    frame("wg age kept", LBF_WIRED, mac(8'he1), mac(8'h10), 16, 1'b0, 1'b1, 0);
    wait_ticks(1925);
    frame("wg age gone", LBF_WIRED, mac(8'he1), mac(8'h10), 16, 1'b0, 1'b0, 0);
    $display("test workgroup aging done");
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (6) @(negedge ref_clk);
    `TB_CHK("reset rx_ready", 1'b0, rx_ready)
    `TB_CHK("reset tx_valid", 1'b0, tx_valid)
    resetn = 1'b1;
    repeat (2) @(negedge ref_clk);
    t_workgroup();
    t_full();
    t_bad();
    t_stall();
    t_age_full();
    t_age_wg();
    close_out();
  end
endmodule
